// >>> include/obuf_pkg.sv
// Package: register map, field layout and carriers of the output buffer readout
package obuf_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] HEADER_ONE_OFFSET   = 12'h700;
    localparam logic [11:0] HEADER_TWO_OFFSET   = 12'h704;
    localparam logic [11:0] HEADER_THREE_OFFSET = 12'h708;
    // Data words occupy 64 aligned words starting here
    localparam logic [11:0] DATA_BASE_OFFSET    = 12'h600;
    localparam int DATA_REGS  = 64;
    localparam int HALF_WORDS = 128;
    localparam logic [31:0] ZERO_WORD = 32'h0;
    localparam logic [6:0]  ZERO_LEN  = 7'h0;

    // Header word one fields as configured by the host
    typedef struct packed {
        logic [10:0] frameIdentifier;
        logic [6:0]  repetitionFilterCode;
        logic        firstLineFilter;
        logic        secondLineFilter;
        logic        directionConfig;
        logic        preambleFlagTx;
        logic        sendMode;
        logic        bufferIrqEnable;
    } header_one_type;

    // Header word two and three fields
    typedef struct packed {
        logic [10:0] headerCrc;
        logic [6:0]  payloadLenConfigured;
        logic [6:0]  payloadLenReceived;
        logic [10:0] dataPointer;
        logic [5:0]  arrivalCycleCount;
        logic        arrivalLineFlag;
        logic        startupFrameFlag;
        logic        timingFrameFlag;
        logic        dataFrameStoredFlag;
        logic        preambleFlag;
        logic        spareHeaderBit;
    } header_rest_type;

    // One write from the message handler into the shadow half
    typedef struct packed {
        logic        headerValid;
        logic        fifoBuffer;
        logic        dataFrame;
        logic        receiveBuffer;
        header_one_type  one;
        header_rest_type rest;
        logic        wordValid;
        logic [6:0]  wordIndex;
        logic [15:0] wordData;
    } shadow_write_type;

    // Host register port
    typedef struct packed {
        logic [11:0] address;
        logic [31:0] writeData;
        logic        writeStrobe;
        logic        readStrobe;
    } host_bus_type;
endpackage : obuf_pkg

// >>> rtl/output_buffer_readout.sv
// Output buffer readout: host half, shadow half, swap and register read port
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// ============================================================
module output_buffer_readout (
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  wire obuf_pkg::host_bus_type     hostBus,
    input  wire obuf_pkg::shadow_write_type shadowWrite,
    input  wire logic                       swapHalves,
    input  wire logic                       wipeMemoriesCommand,
    output logic [31:0]                     readData,
    output logic                            shadowBusy
);
    typedef struct packed {
        obuf_pkg::header_one_type  oneHost;
        obuf_pkg::header_rest_type restHost;
        logic [2047:0]             dataHost;
        obuf_pkg::header_one_type  oneShadow;
        obuf_pkg::header_rest_type restShadow;
        logic [2047:0]             dataShadow;
        logic [31:0]               readData;
        logic                      shadowBusy;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // ============================================================
    // Helpers
    // Word limit: configured length rounded up to even
    function automatic logic [7:0] stored_words(input logic [6:0] cfg);
        stored_words = {1'b0, cfg} + {7'h0, cfg[0]};
    endfunction : stored_words

    logic [31:0] headerOneWord;
    logic [31:0] headerTwoWord;
    logic [31:0] headerThreeWord;
    logic [31:0] dataWord;
    logic [5:0]  dataIndex;
    logic        isData;

    always_comb begin
        headerOneWord = obuf_pkg::ZERO_WORD;
        headerOneWord[10:0]  = state_reg.oneHost.frameIdentifier;
        headerOneWord[22:16] = state_reg.oneHost.repetitionFilterCode;
        headerOneWord[24]    = state_reg.oneHost.firstLineFilter;
        headerOneWord[25]    = state_reg.oneHost.secondLineFilter;
        headerOneWord[26]    = state_reg.oneHost.directionConfig;
        headerOneWord[27]    = state_reg.oneHost.preambleFlagTx;
        headerOneWord[28]    = state_reg.oneHost.sendMode;
        headerOneWord[29]    = state_reg.oneHost.bufferIrqEnable;

        headerTwoWord = obuf_pkg::ZERO_WORD;
        headerTwoWord[10:0]  = state_reg.restHost.headerCrc;
        headerTwoWord[22:16] = state_reg.restHost.payloadLenConfigured;
        headerTwoWord[30:24] = state_reg.restHost.payloadLenReceived;

        headerThreeWord = obuf_pkg::ZERO_WORD;
        headerThreeWord[10:0]  = state_reg.restHost.dataPointer;
        headerThreeWord[21:16] = state_reg.restHost.arrivalCycleCount;
        headerThreeWord[24]    = state_reg.restHost.arrivalLineFlag;
        headerThreeWord[25]    = state_reg.restHost.startupFrameFlag;
        headerThreeWord[26]    = state_reg.restHost.timingFrameFlag;
        headerThreeWord[27]    = state_reg.restHost.dataFrameStoredFlag;
        headerThreeWord[28]    = state_reg.restHost.preambleFlag;
        headerThreeWord[29]    = state_reg.restHost.spareHeaderBit;

        isData    = hostBus.address[11:8] == obuf_pkg::DATA_BASE_OFFSET[11:8];
        dataIndex = hostBus.address[7:2];
        // Earlier word low, later high; last register's high half holds word 127
        dataWord  = state_reg.dataHost[dataIndex*32 +: 32];
    end

    // ============================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        state_next.readData = obuf_pkg::ZERO_WORD;
        // Host writes touch nothing here
        if (hostBus.readStrobe) begin
            if (isData) begin
                state_next.readData = dataWord;
            end else begin
                case (hostBus.address)
                    obuf_pkg::HEADER_ONE_OFFSET:   state_next.readData = headerOneWord;
                    obuf_pkg::HEADER_TWO_OFFSET:   state_next.readData = headerTwoWord;
                    obuf_pkg::HEADER_THREE_OFFSET: state_next.readData = headerThreeWord;
                    default:                       state_next.readData = obuf_pkg::ZERO_WORD;
                endcase
            end
        end

        // Shadow fill by the message handler
        if (shadowWrite.headerValid) begin
            state_next.shadowBusy = 1'b1;
            if (shadowWrite.fifoBuffer) begin
                state_next.oneShadow = '0;
                state_next.oneShadow.frameIdentifier = shadowWrite.one.frameIdentifier;
                state_next.restShadow.payloadLenReceived =
                    shadowWrite.rest.payloadLenReceived;
            end else begin
                state_next.oneShadow = shadowWrite.one;
            end
            state_next.restShadow.payloadLenConfigured =
                shadowWrite.rest.payloadLenConfigured;
            state_next.restShadow.dataPointer = shadowWrite.rest.dataPointer;
            if (!shadowWrite.receiveBuffer) begin
                state_next.restShadow.headerCrc = shadowWrite.rest.headerCrc;
            end
            if (shadowWrite.dataFrame) begin
                if (shadowWrite.receiveBuffer) begin
                    state_next.restShadow.headerCrc = shadowWrite.rest.headerCrc;
                end
                state_next.restShadow.payloadLenReceived =
                    shadowWrite.rest.payloadLenReceived;
                state_next.restShadow.arrivalCycleCount =
                    shadowWrite.rest.arrivalCycleCount;
                state_next.restShadow.arrivalLineFlag =
                    shadowWrite.rest.arrivalLineFlag;
                state_next.restShadow.startupFrameFlag =
                    shadowWrite.rest.startupFrameFlag;
                state_next.restShadow.timingFrameFlag =
                    shadowWrite.rest.timingFrameFlag;
                state_next.restShadow.dataFrameStoredFlag = 1'b1;
                state_next.restShadow.preambleFlag = shadowWrite.rest.preambleFlag;
                state_next.restShadow.spareHeaderBit =
                    shadowWrite.rest.spareHeaderBit;
            end
        end

        // Words beyond the even-rounded configured length are dropped;
        // a zero length drops every word. Unwritten words keep old content.
        if (shadowWrite.wordValid &&
            {1'b0, shadowWrite.wordIndex} <
                stored_words(state_next.restShadow.payloadLenConfigured)) begin
            state_next.dataShadow[shadowWrite.wordIndex*16 +: 16] = shadowWrite.wordData;
        end

        // Swap: shadow contents become visible to the host
        if (swapHalves) begin
            state_next.oneHost    = state_next.oneShadow;
            state_next.restHost   = state_next.restShadow;
            state_next.dataHost   = state_next.dataShadow;
            state_next.oneShadow  = state_reg.oneHost;
            state_next.restShadow = state_reg.restHost;
            state_next.dataShadow = state_reg.dataHost;
            state_next.shadowBusy = 1'b0;
        end

        if (wipeMemoriesCommand) begin
            state_next = '0;
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign readData   = state_reg.readData;
    assign shadowBusy = state_reg.shadowBusy;
endmodule : output_buffer_readout
`default_nettype wire

// >>> dv/output_buffer_readout_assertions.sv
// Checker: port-level properties of the output buffer readout
`timescale 1ns/10ps
`default_nettype none
module obuf_checker (
    input wire logic                       sys_clk,
    input wire logic                       reset,
    input wire obuf_pkg::host_bus_type     hostBus,
    input wire obuf_pkg::shadow_write_type shadowWrite,
    input wire logic                       swapHalves,
    input wire logic                       wipeMemoriesCommand,
    input wire logic [31:0]                readData,
    input wire logic                       shadowBusy
);
    // ========
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic rd1;
    logic rd2;
    logic rd3;
    logic ctl;
    assign rd1 = hostBus.readStrobe && hostBus.address == obuf_pkg::HEADER_ONE_OFFSET;
    assign rd2 = hostBus.readStrobe && hostBus.address == obuf_pkg::HEADER_TWO_OFFSET;
    assign rd3 = hostBus.readStrobe && hostBus.address == obuf_pkg::HEADER_THREE_OFFSET;
    assign ctl = swapHalves || wipeMemoriesCommand;
    a_idle_read_zero: assert property (!hostBus.readStrobe |=> readData == 32'h0)
        else $error("read data not zero while idle");
    a_unmapped_zero: assert property (hostBus.readStrobe && hostBus.address == 12'h7f0
        |=> readData == 32'h0) else $error("unmapped read not zero");
    a_busy_on_header: assert property (shadowWrite.headerValid && !ctl |=> shadowBusy)
        else $error("busy not set by header load");
    a_busy_holds: assert property (shadowBusy && !ctl |=> shadowBusy)
        else $error("busy dropped without swap");
    a_busy_off_swap: assert property (swapHalves |=> !shadowBusy)
        else $error("busy not cleared by swap");
    a_wipe_read: assert property (wipeMemoriesCommand ##1 (hostBus.readStrobe && !swapHalves)
        |=> readData == 32'h0) else $error("data after wipe not zero");
    a_hdr_one_zero: assert property (rd1 |=> readData[31:30] == 2'h0 && !readData[23]
        && readData[15:11] == 5'h0) else $error("header one spare bits set");
    a_hdr_two_zero: assert property (rd2 |=> !readData[31] && !readData[23]
        && readData[15:11] == 5'h0) else $error("header two spare bits set");
    a_hdr_three_zero: assert property (rd3 |=> readData[31:30] == 2'h0
        && readData[23:22] == 2'h0 && readData[15:11] == 5'h0) else $error("header three spare");
    c_swap: cover property (shadowBusy ##1 swapHalves);
    c_wipe: cover property (wipeMemoriesCommand);
    c_read: cover property (rd2 ##1 readData != 32'h0);
endmodule : obuf_checker
bind output_buffer_readout obuf_checker u_obuf_checker (.sys_clk(sys_clk), .reset(reset),
    .hostBus(hostBus), .shadowWrite(shadowWrite), .swapHalves(swapHalves),
    .wipeMemoriesCommand(wipeMemoriesCommand), .readData(readData), .shadowBusy(shadowBusy));
`default_nettype wire

// >>> dv/handler_model.sv
// Partner: message handler model that fills the shadow half
`timescale 1ns/10ps
`default_nettype none
module handler_model (
    input  wire logic                      sys_clk,
    output var obuf_pkg::shadow_write_type shadowWrite
);
    // ========
    // Transfers, one-cycle pulses into the shadow half
    initial shadowWrite = '0;
    // Frame kind and buffer direction are chosen per call so that null frames,
    // transmit buffers and FIFO buffers all reach the shadow half
    task automatic hdr(input logic fifo, input logic data, input logic rx,
                       input logic [23:0] one, input logic [47:0] rest);
        @(posedge sys_clk);
        shadowWrite.headerValid <= 1'b1;
        shadowWrite.fifoBuffer <= fifo;
        shadowWrite.dataFrame <= data;
        shadowWrite.receiveBuffer <= rx;
        shadowWrite.one <= one;
        shadowWrite.rest <= rest;
        @(posedge sys_clk);
        shadowWrite.headerValid <= 1'b0;
    endtask : hdr
    task automatic word(input logic [6:0] idx, input logic [15:0] data);
        @(posedge sys_clk);
        shadowWrite.wordValid <= 1'b1;
        shadowWrite.wordIndex <= idx;
        shadowWrite.wordData <= data;
        @(posedge sys_clk);
        shadowWrite.wordValid <= 1'b0;
    endtask : word
endmodule : handler_model
`default_nettype wire

// >>> dv/testbench.sv
// Testbench: directed scenarios for the output buffer readout
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                       sys_clk;
    logic                       reset;
    obuf_pkg::host_bus_type     hb;
    obuf_pkg::shadow_write_type sw;
    logic                       swp;
    logic                       wipe;
    logic [31:0]                readData;
    logic                       busy;
    int                         mismatches;
    int                         samples_checked;
    localparam logic [11:0] H1 = obuf_pkg::HEADER_ONE_OFFSET;
    localparam logic [11:0] H2 = obuf_pkg::HEADER_TWO_OFFSET;
    localparam logic [11:0] H3 = obuf_pkg::HEADER_THREE_OFFSET;
    localparam logic [11:0] DB = obuf_pkg::DATA_BASE_OFFSET;
    localparam logic [23:0] ONE = {11'h2a5, 7'h45, 6'b100101};
    localparam logic [47:0] REST = {11'h3c1, 7'h03, 7'h05, 11'h155, 6'h2b, 6'b101101};
    localparam logic [47:0] REST0 = {11'h3c1, 7'h00, 7'h05, 11'h155, 6'h2b, 6'b101101};
    localparam logic [47:0] REST2 = {11'h07e, 7'h04, 7'h09, 11'h0aa, 6'h11, 6'b010010};
    output_buffer_readout u_output_buffer_readout (.sys_clk(sys_clk), .reset(reset),
        .hostBus(hb), .shadowWrite(sw), .swapHalves(swp), .wipeMemoriesCommand(wipe),
        .readData(readData), .shadowBusy(busy));
    handler_model u_handler_model (.sys_clk(sys_clk), .shadowWrite(sw));
    // ========
    // Bus cycles and checks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: read data %h, want %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk) hb.address <= a;
        hb.readStrobe <= 1'b1;
        @(posedge sys_clk) hb.readStrobe <= 1'b0;
        #1 check(readData, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a);
        @(posedge sys_clk) hb.address <= a;
        hb.writeData <= 32'hffffffff;
        hb.writeStrobe <= 1'b1;
        @(posedge sys_clk) hb.writeStrobe <= 1'b0;
    endtask : wr
    task automatic pulse_swap;
        @(posedge sys_clk) swp <= 1'b1;
        @(posedge sys_clk) swp <= 1'b0;
    endtask : pulse_swap
    // ========
    // Scenarios
    task automatic t_fill;
        u_handler_model.hdr(1'b0, 1'b1, 1'b1, ONE, REST);
        #1 check({31'h0, busy}, 32'h1);
        // Six words against an odd length of three: only four may land
        for (int i = 0; i < 6; i++) u_handler_model.word(7'(i), 16'h1100 + 16'(i));
        pulse_swap();
        #1 check({31'h0, busy}, 32'h0);
        rd(H1, {2'h0, 6'b101001, 1'b0, 7'h45, 5'h0, 11'h2a5});
        rd(H2, {1'b0, 7'h05, 1'b0, 7'h03, 5'h0, 11'h3c1});
        rd(H3, {2'h0, 6'b101101, 2'h0, 6'h2b, 5'h0, 11'h155});
        rd(DB, 32'h11011100);
        rd(DB + 12'h4, 32'h11031102);
        rd(DB + 12'h8, 32'h0);
        rd(12'h7f0, 32'h0);
    endtask : t_fill
    task automatic t_write;
        wr(H2);
        wr(DB);
        rd(H2, {1'b0, 7'h05, 1'b0, 7'h03, 5'h0, 11'h3c1});
        rd(DB, 32'h11011100);
    endtask : t_write
    task automatic t_fifo;
        u_handler_model.hdr(1'b1, 1'b1, 1'b1, ONE, REST);
        pulse_swap();
        rd(H1, {21'h0, 11'h2a5});
    endtask : t_fifo
    // Null frames and a transmit buffer: received fields must hold their old values, except the FIFO buffer's received length
    task automatic t_null;
        u_handler_model.hdr(1'b0, 1'b0, 1'b1, ONE, REST2);
        pulse_swap();
        rd(H2, {1'b0, 7'h05, 1'b0, 7'h04, 5'h0, 11'h3c1});
        rd(H3, {2'h0, 6'b101101, 2'h0, 6'h2b, 5'h0, 11'h0aa});
        u_handler_model.hdr(1'b0, 1'b0, 1'b0, ONE, REST2);
        pulse_swap();
        rd(H2, {1'b0, 7'h05, 1'b0, 7'h04, 5'h0, 11'h07e});
        u_handler_model.hdr(1'b1, 1'b0, 1'b1, ONE, REST2);
        pulse_swap();
        rd(H2, {1'b0, 7'h09, 1'b0, 7'h04, 5'h0, 11'h3c1});
    endtask : t_null
    task automatic t_wipe_zero;
        @(posedge sys_clk) wipe <= 1'b1;
        @(posedge sys_clk) wipe <= 1'b0;
        rd(DB, 32'h0);
        rd(H1, 32'h0);
        u_handler_model.hdr(1'b0, 1'b1, 1'b1, ONE, REST0);
        u_handler_model.word(7'h0, 16'hbeef);
        pulse_swap();
        rd(DB, 32'h0);
    endtask : t_wipe_zero
    task automatic report_and_stop;
        if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        reset = 1'b1;
        hb = '0;
        swp = 1'b0;
        wipe = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        rd(H1, 32'h0);
        rd(H3, 32'h0);
        t_fill();
        t_write();
        t_fifo();
        t_null();
        t_wipe_zero();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
